// File: src/acc_pkg.sv
/*
 * Shared constants and types of the conversion controller.
 * Assumes a single 50 MHz clock and no register bus.
 */
package acc_pkg;
	localparam int ACC_CHANNELS = 12;
	localparam int ACC_CH_W = 4;
	localparam int ACC_DATA_W = 10;
	localparam int ACC_LOW_W = 8;
	localparam int ACC_DMA_W = 16;
	localparam int ACC_DIV_W = 8;
	localparam int ACC_TRACK_W = 4;
	localparam int ACC_XFER_W = 2;
	localparam int ACC_PER_W = 16;
	localparam logic [ACC_DIV_W-1:0] ACC_DIV_RESET = 8'h00;
	localparam logic [ACC_DATA_W-1:0] ACC_DATA_RESET = 10'h000;
	localparam logic [ACC_CH_W-1:0] ACC_TAG_POS_RESET = 4'h0;
	localparam int ACC_TAG_LSB = 12;
	localparam int ACC_SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ACC_TRG_SOFT = 3'h0,
		ACC_TRG_RISE = 3'h1,
		ACC_TRG_FALL = 3'h2,
		ACC_TRG_ANY = 3'h3,
		ACC_TRG_CONT = 3'h4,
		ACC_TRG_PERIOD = 3'h5
	} acc_trig_mode_t;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_TRACK = 2'b01,
		ACC_XFER = 2'b11
	} acc_state_t;
endpackage : acc_pkg

// File: src/acc_result_if.sv
/*
 * Carries one finished conversion from the sequencer to the result store.
 * Assumes both ends share the controller clock.
 */
`timescale 1ns/100ps
interface acc_result_if;
	import acc_pkg::*;
	logic valid;
	logic [ACC_CH_W-1:0] chan;
	logic [ACC_DATA_W-1:0] data;
	modport source (output valid, output chan, output data);
	modport sink (input valid, input chan, input data);
endinterface : acc_result_if

// File: src/acc_clock_divider.sv
/*
 * Converter clock enable generator.
 * Assumes the divide setting is static while conversions run.
 */
`timescale 1ns/100ps
module acc_clock_divider
	import acc_pkg::*;
#(
	parameter int DIV_W = ACC_DIV_W
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Setting and enable.
	input wire logic [DIV_W-1:0] setting_i,
	output logic tick_o
);
	logic [DIV_W:0] count_r;
	logic [DIV_W:0] limit;

	// One converter clock period is 2*(setting+1) master clocks.
	assign limit = {setting_i, 1'b1};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= '0;
			tick_o <= 1'b0;
		end else if (count_r >= limit) begin
			count_r <= '0;
			tick_o <= 1'b1;
		end else begin
			count_r <= count_r + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule : acc_clock_divider

// File: src/acc_controller.sv
/*
 * Conversion controller: clock division, trigger selection, channel
 * sequencing, result storage, flags and transfer requests.
 * Assumes the analog cell returns a sample on conv_data_i whenever
 * asked, and that reads are one-cycle strobes synchronous to clk_i.
 */
//
// Function
// - Converter clock from 8-bit divide setting.
// - Tracking then transfer cycles give 10 bits.
// - Next tracking overlaps previous conversion.
// - Low resolution gives 8 bits, top zero.
// - Result stored per channel and last.
// - Tag shows channel number in last result.
// - DMA word 16 bits, tag on top.
// - Completion sets channel and ready flags.
// - DMA request on ready rising edge.
// - Reads clear end and ready flags.
// - Unread channel result sets channel overrun if channel still enabled.
// - Store while ready high sets general overrun.
// - Status reads clear overrun flags.
// - Start write triggers a sequence.
// - Mode selects edge, continuous or periodic trigger.
// - Hardware trigger resynchronised before start.
// - One start converts all enabled channels.
// - Enable and disable strobes edit mask.
// - Requests for results of channels enabled at sequence start.
// - Enabled channels route pin, else ground.
// - Configuration accepted while clock gated.
`timescale 1ns/100ps
module acc_controller
	import acc_pkg::*;
#(
	parameter int CHANNELS = ACC_CHANNELS,
	parameter int PER_W = ACC_PER_W
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Gated master clock enable from the power manager.
	input wire logic clock_enable_i,
	// Configuration.
	input wire logic [ACC_DIV_W-1:0] clock_divide_setting_i,
	input wire logic [ACC_TRACK_W-1:0] tracking_cycle_count_i,
	input wire logic [ACC_XFER_W-1:0] transfer_cycle_count_i,
	input wire logic low_resolution_select_i,
	input wire logic tag_enable_i,
	input wire logic [2:0] trigger_mode_select_i,
	input wire logic [PER_W-1:0] trigger_period_value_i,
	// Commands.
	input wire logic start_i,
	input wire logic [CHANNELS-1:0] channel_enable_i,
	input wire logic [CHANNELS-1:0] channel_disable_i,
	// Read strobes.
	input wire logic [CHANNELS-1:0] channel_result_read_i,
	input wire logic last_result_read_i,
	input wire logic main_status_read_i,
	input wire logic overrun_status_read_i,
	// Trigger pin.
	input wire logic external_trigger_input_i,
	// Analog cell.
	input wire logic [ACC_DATA_W-1:0] conv_data_i,
	output logic [CHANNELS-1:0] input_route_o,
	output logic [ACC_CH_W-1:0] mux_select_o,
	output logic sample_o,
	// Results.
	output logic [CHANNELS*ACC_DATA_W-1:0] channel_result_o,
	output logic [ACC_DATA_W-1:0] last_result_value_o,
	output logic [ACC_CH_W-1:0] last_channel_number_o,
	output logic [ACC_DMA_W-1:0] dma_word_o,
	// Flags.
	output logic [CHANNELS-1:0] channel_status_o,
	output logic [CHANNELS-1:0] end_of_conversion_o,
	output logic data_ready_flag_o,
	output logic [CHANNELS-1:0] channel_overrun_flag_o,
	output logic general_overrun_flag_o,
	output logic dma_request_o,
	output logic busy_o
);
	logic rst_meta_r;
	logic rst_n_r;
	logic adc_tick;
	logic active;
	acc_state_t state_r;
	logic [CHANNELS-1:0] mask_r;
	logic [CHANNELS-1:0] pending_r;
	logic [ACC_CH_W-1:0] chan_r;
	logic [ACC_CH_W-1:0] done_chan_r;
	logic [ACC_TRACK_W:0] track_r;
	logic [ACC_XFER_W:0] xfer_r;
	logic trg_d_r;
	logic trg_armed_r;
	logic hw_edge;
	logic [ACC_SYNC_STAGES-1:0] sync_r;
	logic hw_req_r;
	logic soft_req_r;
	logic cont_req;
	logic [PER_W-1:0] per_r;
	logic seq_start;
	logic [CHANNELS-1:0] next_pending;
	logic [ACC_CH_W-1:0] next_chan;
	logic next_found;
	logic [ACC_DATA_W-1:0] result;
	logic [ACC_DATA_W-1:0] result_mask;
	acc_result_if res ();

	// Reset release through two flip-flops.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// Configuration logic runs on the ungated clock; the sequencer
	// advances only while the master clock enable is on.
	assign active = clock_enable_i;

	acc_clock_divider #(
		.DIV_W(ACC_DIV_W)
	) u_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n_r),
		.setting_i(clock_divide_setting_i),
		.tick_o(adc_tick)
	);

	// Channel mask edited by enable and disable strobes; enable wins.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mask_r <= '0;
			input_route_o <= '0;
		end else begin
			mask_r <= (mask_r & ~channel_disable_i) | channel_enable_i;
			input_route_o <= (mask_r & ~channel_disable_i) | channel_enable_i;
		end
	end
	assign channel_status_o = mask_r;

	// Trigger edge detection and resynchronisation. The armed flag masks
	// the first cycle after reset, when the delayed pin copy is not yet
	// valid and a pin held high would look like a rising edge.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			trg_d_r <= 1'b0;
			trg_armed_r <= 1'b0;
			sync_r <= '0;
		end else begin
			trg_d_r <= external_trigger_input_i;
			trg_armed_r <= 1'b1;
			sync_r <= {sync_r[ACC_SYNC_STAGES-2:0],
				hw_edge && trg_armed_r};
		end
	end

	// Only the three edge modes look at the trigger pin.
	always_comb begin
		unique case (acc_trig_mode_t'(trigger_mode_select_i))
			ACC_TRG_RISE: hw_edge = external_trigger_input_i & ~trg_d_r;
			ACC_TRG_FALL: hw_edge = ~external_trigger_input_i & trg_d_r;
			ACC_TRG_ANY: hw_edge = external_trigger_input_i ^ trg_d_r;
			default: hw_edge = 1'b0;
		endcase
	end

	// Periodic trigger counts converter clock periods.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			per_r <= '0;
		end else if (trigger_mode_select_i != ACC_TRG_PERIOD) begin
			per_r <= '0;
		end else if (adc_tick && active) begin
			per_r <= (per_r >= trigger_period_value_i) ? '0 : per_r + 1'b1;
		end
	end

	// Requests wait for the next converter clock; a trigger during a
	// sequence is held as one pending request, since keeping triggers
	// apart is the caller's duty.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hw_req_r <= 1'b0;
			soft_req_r <= 1'b0;
		end else begin
			if (seq_start) begin
				hw_req_r <= 1'b0;
			end else if (sync_r[ACC_SYNC_STAGES-1] ||
				(adc_tick && active && per_r == trigger_period_value_i &&
				trigger_mode_select_i == ACC_TRG_PERIOD)) begin
				hw_req_r <= 1'b1;
			end
			if (seq_start) begin
				soft_req_r <= 1'b0;
			end else if (start_i) begin
				soft_req_r <= 1'b1;
			end
		end
	end
	assign cont_req = trigger_mode_select_i == ACC_TRG_CONT;
	assign seq_start = state_r == ACC_IDLE && adc_tick && active &&
		(hw_req_r || soft_req_r || cont_req) && |mask_r;

	// Lowest pending channel is next.
	always_comb begin
		next_found = 1'b0;
		next_chan = '0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (next_pending[i]) begin
				next_found = 1'b1;
				next_chan = ACC_CH_W'(i);
			end
		end
	end
	assign next_pending = (state_r == ACC_IDLE) ? mask_r :
		(pending_r & ~(CHANNELS'(1) << chan_r));

	// Sequencer: tracking of the next channel overlaps the previous
	// transfer, so tracking only adds what the transfer did not cover.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ACC_IDLE;
			pending_r <= '0;
			chan_r <= '0;
			track_r <= '0;
			xfer_r <= '0;
			sample_o <= 1'b0;
			done_chan_r <= '0;
			busy_o <= 1'b0;
		end else begin
			sample_o <= 1'b0;
			if (adc_tick && active) begin
				unique case (state_r)
					ACC_IDLE: begin
						if (seq_start) begin
							state_r <= ACC_TRACK;
							busy_o <= 1'b1;
							pending_r <= mask_r;
							chan_r <= next_chan;
							track_r <= '0;
						end
					end
					ACC_TRACK: begin
						if (track_r >= {1'b0, tracking_cycle_count_i}) begin
							state_r <= ACC_XFER;
							xfer_r <= '0;
						end else begin
							track_r <= track_r + 1'b1;
						end
					end
					ACC_XFER: begin
						if (xfer_r >= {1'b0, transfer_cycle_count_i}) begin
							sample_o <= 1'b1;
							// Keep the finished channel; chan_r moves on now.
							done_chan_r <= chan_r;
							pending_r <= next_pending;
							if (next_found) begin
								chan_r <= next_chan;
								state_r <= ACC_TRACK;
								// Tracking already ran during this transfer.
								track_r <= ACC_TRACK_W'(xfer_r) + 1'b1;
							end else begin
								state_r <= ACC_IDLE;
								busy_o <= 1'b0;
							end
						end else begin
							xfer_r <= xfer_r + 1'b1;
						end
					end
					default: begin
						state_r <= ACC_IDLE;
						busy_o <= 1'b0;
					end
				endcase
			end
		end
	end
	assign mux_select_o = chan_r;

	// Result formatting; low resolution keeps the upper eight bits.
	assign result_mask = low_resolution_select_i ?
		ACC_DATA_W'((1 << ACC_LOW_W) - 1) : '1;
	assign result = low_resolution_select_i ?
		(conv_data_i >> (ACC_DATA_W - ACC_LOW_W)) & result_mask :
		conv_data_i;

	assign res.valid = sample_o;
	assign res.chan = done_chan_r;
	assign res.data = result;

	// Per-channel results with their end and overrun flags.
	acc_result_store #(
		.CHANNELS(CHANNELS)
	) u_store (
		.clk_i(clk_i),
		.rst_n_i(rst_n_r),
		.res(res.sink),
		.mask_i(mask_r),
		.channel_read_i(channel_result_read_i),
		.overrun_read_i(overrun_status_read_i),
		.channel_result_o(channel_result_o),
		.eoc_o(end_of_conversion_o),
		.overrun_o(channel_overrun_flag_o)
	);

	// Last result, tag and DMA word.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			last_result_value_o <= ACC_DATA_RESET;
			last_channel_number_o <= ACC_TAG_POS_RESET;
			dma_word_o <= '0;
		end else if (res.valid) begin
			last_result_value_o <= res.data;
			last_channel_number_o <= tag_enable_i ? res.chan : '0;
			dma_word_o <= {(tag_enable_i ? res.chan : ACC_CH_W'(0)),
				2'b00, res.data};
		end
	end

	// Ready and general overrun; the set wins over a clearing read.
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			data_ready_flag_o <= 1'b0;
			general_overrun_flag_o <= 1'b0;
			dma_request_o <= 1'b0;
		end else begin
			if (res.valid) begin
				data_ready_flag_o <= 1'b1;
			end else if (last_result_read_i) begin
				data_ready_flag_o <= 1'b0;
			end
			if (res.valid && data_ready_flag_o) begin
				general_overrun_flag_o <= 1'b1;
			end else if (main_status_read_i) begin
				general_overrun_flag_o <= 1'b0;
			end
			// Sequencer only visits channels enabled when the sequence began.
			dma_request_o <= res.valid && (!data_ready_flag_o ||
				last_result_read_i);
		end
	end
endmodule : acc_controller

// File: src/acc_result_store.sv
/*
 * Per-channel result registers with end-of-conversion and overrun flags.
 * Assumes read strobes are one-cycle pulses on the controller clock.
 */
`timescale 1ns/100ps
module acc_result_store
	import acc_pkg::*;
#(
	parameter int CHANNELS = ACC_CHANNELS
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// New result.
	acc_result_if.sink res,
	input wire logic [CHANNELS-1:0] mask_i,
	// Reads.
	input wire logic [CHANNELS-1:0] channel_read_i,
	input wire logic overrun_read_i,
	// State.
	output logic [CHANNELS*ACC_DATA_W-1:0] channel_result_o,
	output logic [CHANNELS-1:0] eoc_o,
	output logic [CHANNELS-1:0] overrun_o
);
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		logic hit;
		assign hit = res.valid && res.chan == ACC_CH_W'(i);
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				channel_result_o[i*ACC_DATA_W +: ACC_DATA_W] <= ACC_DATA_RESET;
				eoc_o[i] <= 1'b0;
				overrun_o[i] <= 1'b0;
			end else begin
				if (hit) begin
					channel_result_o[i*ACC_DATA_W +: ACC_DATA_W] <= res.data;
					eoc_o[i] <= 1'b1;
				end else if (channel_read_i[i]) begin
					eoc_o[i] <= 1'b0;
				end
				if (hit && eoc_o[i] && mask_i[i]) begin
					overrun_o[i] <= 1'b1;
				end else if (overrun_read_i) begin
					overrun_o[i] <= 1'b0;
				end
			end
		end
	end
endmodule : acc_result_store

// File: sim/acc_cell_model.sv
/*
 * Behavioural analog cell that answers each sample strobe with a new value.
 * Assumes the controller captures the value in the cycle sample_i is high.
 */
`timescale 1ns/100ps
module acc_cell_model
	import acc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Converter side.
	input wire logic sample_i,
	output logic [ACC_DATA_W-1:0] conv_data_o
);
	logic [ACC_DATA_W-1:0] value_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			value_r <= 10'h2A7;
		end else if (sample_i) begin
			value_r <= value_r + 10'h05B;
		end
	end

	// Outside the sample cycle the value is inverted so stale data shows.
	assign conv_data_o = sample_i ? value_r : ~value_r;
endmodule : acc_cell_model

// File: sim/acc_checker.sv
/*
 * Concurrent checks on the conversion controller's ports.
 * Assumes it is bound into acc_controller and sees its ports only.
 */
`timescale 1ns/100ps
module acc_checker
	import acc_pkg::*;
#(
	parameter int CHANNELS = ACC_CHANNELS
) (
	// Clock, reset and inputs.
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clock_enable_i,
	input wire logic low_resolution_select_i,
	input wire logic start_i,
	input wire logic last_result_read_i,
	input wire logic main_status_read_i,
	input wire logic overrun_status_read_i,
	input wire logic [ACC_DATA_W-1:0] conv_data_i,
	// Outputs.
	input wire logic sample_o,
	input wire logic [ACC_DATA_W-1:0] last_result_value_o,
	input wire logic [ACC_CH_W-1:0] last_channel_number_o,
	input wire logic [ACC_DMA_W-1:0] dma_word_o,
	input wire logic [CHANNELS-1:0] channel_status_o,
	input wire logic data_ready_flag_o,
	input wire logic [CHANNELS-1:0] channel_overrun_flag_o,
	input wire logic general_overrun_flag_o,
	input wire logic dma_request_o,
	input wire logic busy_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_start;
		start_i && !busy_o && clock_enable_i && (|channel_status_o);
	endsequence
	sequence s_store;
		sample_o ##1 data_ready_flag_o;
	endsequence

	start_run_a: assert property (s_start |-> ##[1:600] busy_o)
		else $error("start did not begin a sequence");
	store_ready_a: assert property (sample_o |-> s_store)
		else $error("ready flag not set after sample");
	full_res_a: assert property (sample_o && !low_resolution_select_i
		|=> last_result_value_o == $past(conv_data_i))
		else $error("last result differs from sample");
	low_res_a: assert property (sample_o && low_resolution_select_i
		|=> last_result_value_o == ($past(conv_data_i) >> 2))
		else $error("low resolution result wrong");
	dma_rise_a: assert property ($rose(data_ready_flag_o) |-> dma_request_o)
		else $error("no request on ready rise");
	dma_pulse_a: assert property (dma_request_o |=> !dma_request_o)
		else $error("request longer than one cycle");
	dma_word_a: assert property (dma_request_o |-> dma_word_o ==
		{last_channel_number_o, 2'b00, last_result_value_o})
		else $error("transfer word layout wrong");
	ready_clear_a: assert property (last_result_read_i && !sample_o
		|=> !data_ready_flag_o)
		else $error("ready flag not cleared by read");
	general_set_a: assert property (sample_o && data_ready_flag_o
		&& !last_result_read_i |=> general_overrun_flag_o)
		else $error("general overrun not set");
	general_clear_a: assert property (main_status_read_i && !sample_o
		|=> !general_overrun_flag_o)
		else $error("general overrun not cleared");
	ovr_clear_a: assert property (overrun_status_read_i && !sample_o
		|=> channel_overrun_flag_o == '0)
		else $error("channel overrun not cleared");
endmodule : acc_checker

bind acc_controller acc_checker #(.CHANNELS(CHANNELS)) u_chk (.clk_i,
	.reset_n_i, .clock_enable_i, .low_resolution_select_i, .start_i,
	.last_result_read_i, .main_status_read_i, .overrun_status_read_i,
	.conv_data_i, .sample_o, .last_result_value_o, .last_channel_number_o,
	.dma_word_o, .channel_status_o, .data_ready_flag_o,
	.channel_overrun_flag_o, .general_overrun_flag_o, .dma_request_o,
	.busy_o);

// File: sim/acc_controller_tb.sv
/*
 * Self-checking bench of the conversion controller.
 * Assumes the cell model answers samples and the checker is bound.
 */
`timescale 1ns/100ps
module acc_controller_tb;
	import acc_pkg::*;
	localparam int CH = ACC_CHANNELS;
	logic clk_i = 1'h0, reset_n_i = 1'h0, clock_enable_i = 1'h1;
	logic [ACC_DIV_W-1:0] clock_divide_setting_i = 8'h01;
	logic [ACC_TRACK_W-1:0] tracking_cycle_count_i = 4'h3;
	logic [ACC_XFER_W-1:0] transfer_cycle_count_i = 2'h0;
	logic low_resolution_select_i = 1'h0, tag_enable_i = 1'h1;
	logic [2:0] trigger_mode_select_i = 3'h0;
	logic [15:0] trigger_period_value_i = 16'h0040;
	logic start_i = 1'h0, last_result_read_i = 1'h0;
	logic main_status_read_i = 1'h0, overrun_status_read_i = 1'h0;
	logic external_trigger_input_i = 1'h0;
	logic [CH-1:0] channel_enable_i = '0, channel_disable_i = '0;
	logic [CH-1:0] channel_result_read_i = '0;
	logic [ACC_DATA_W-1:0] conv_data_i, last_result_value_o, v;
	logic [CH-1:0] input_route_o, channel_status_o, end_of_conversion_o;
	logic [CH-1:0] channel_overrun_flag_o;
	logic [ACC_CH_W-1:0] mux_select_o, last_channel_number_o, mx;
	logic [CH*ACC_DATA_W-1:0] channel_result_o;
	logic [ACC_DMA_W-1:0] dma_word_o;
	logic sample_o, data_ready_flag_o, general_overrun_flag_o;
	logic dma_request_o, busy_o;
	int errors = 0, n_compared = 0, n_dma = 0, t, s0, s1;

	acc_controller u_dut (.clk_i, .reset_n_i, .clock_enable_i,
		.clock_divide_setting_i, .tracking_cycle_count_i,
		.transfer_cycle_count_i, .low_resolution_select_i, .tag_enable_i,
		.trigger_mode_select_i, .trigger_period_value_i, .start_i,
		.channel_enable_i, .channel_disable_i, .channel_result_read_i,
		.last_result_read_i, .main_status_read_i, .overrun_status_read_i,
		.external_trigger_input_i, .conv_data_i, .input_route_o,
		.mux_select_o, .sample_o, .channel_result_o, .last_result_value_o,
		.last_channel_number_o, .dma_word_o, .channel_status_o,
		.end_of_conversion_o, .data_ready_flag_o, .channel_overrun_flag_o,
		.general_overrun_flag_o, .dma_request_o, .busy_o);
	acc_cell_model u_cell (.clk_i, .reset_n_i, .sample_i(sample_o),
		.conv_data_o(conv_data_i));

	initial begin
		forever #10 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		if (dma_request_o === 1'b1) n_dma++;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step

	// Strobe bits are {start, last read, main status read, overrun read}.
	task automatic strobe(input logic [CH-1:0] en, dis, rd,
		input logic [3:0] k);
		channel_enable_i = en;
		channel_disable_i = dis;
		channel_result_read_i = rd;
		{start_i, last_result_read_i, main_status_read_i,
			overrun_status_read_i} = k;
		step();
		channel_enable_i = '0;
		channel_disable_i = '0;
		channel_result_read_i = '0;
		{start_i, last_result_read_i, main_status_read_i,
			overrun_status_read_i} = 4'h0;
		step();
	endtask : strobe

	// Returns the spacing in clocks and the value the cell handed over.
	task automatic wait_smp(output int c);
		c = 1;
		mx = mux_select_o;
		step();
		while (sample_o !== 1'b1 && c < 3000) begin
			mx = mux_select_o;
			step();
			c++;
		end
		chk(c < 3000, 1'b1);
		v = conv_data_i;
	endtask : wait_smp

	task automatic idle();
		t = 0;
		while (busy_o !== 1'b0 && t < 20000) begin
			step();
			t++;
		end
		chk(busy_o, 1'b0);
	endtask : idle

	task automatic seq(input logic [CH-1:0] m, input logic lo, tg, rd);
		logic f;
		f = 1'b1;
		for (int c = 0; c < CH; c++) begin
			if (m[c]) begin
				wait_smp(t);
				step();
				if (lo) v = v >> 2;
				chk(channel_result_o[c*ACC_DATA_W+:ACC_DATA_W], v);
				chk(end_of_conversion_o[c], 1'b1);
				chk(mx, c[3:0]);
				chk(last_result_value_o, v);
				chk(last_channel_number_o, tg ? c[3:0] : 4'h0);
				chk(dma_word_o, {tg ? c[3:0] : 4'h0, 2'b00, v});
				chk(dma_request_o, rd | f);
				f = 1'b0;
				if (rd) begin
					strobe('0, '0, '0, 4'h4);
					chk(data_ready_flag_o, 1'b0);
				end
			end
		end
	endtask : seq

	task automatic hw(input logic [2:0] md, input logic pin, yes);
		trigger_mode_select_i = 3'h0;
		step();
		idle();
		trigger_mode_select_i = md;
		external_trigger_input_i = pin;
		t = 0;
		step();
		while (busy_o !== 1'b1 && t < 300) begin
			step();
			t++;
		end
		chk(busy_o, yes);
		if (yes && md != 3'h4) chk(t >= 2, 1'b1);
		step(150);
	endtask : hw

	task automatic spc(input logic [7:0] n, input logic [3:0] tr,
		input logic [1:0] xf, output int s);
		clock_divide_setting_i = n;
		tracking_cycle_count_i = tr;
		transfer_cycle_count_i = xf;
		strobe('0, '0, '0, 4'h8);
		wait_smp(s);
		wait_smp(s);
		idle();
	endtask : spc

	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#1500000;
		errors++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		#1 reset_n_i = 1'h1;
		step(3);
		chk(channel_status_o, 12'h000);
		chk(input_route_o, 12'h000);
		strobe(12'h827, '0, '0, 4'h0);
		strobe('0, 12'h003, '0, 4'h0);
		strobe(12'h001, 12'h001, '0, 4'h0);
		chk(channel_status_o, 12'h825);
		step(3);
		chk(input_route_o, 12'h825);
		strobe('0, '0, '0, 4'h8);
		seq(12'h825, 1'b0, 1'b1, 1'b1);
		idle();
		step(100);
		chk(busy_o, 1'b0);
		chk(n_dma, 4);
		tag_enable_i = 1'h0;
		low_resolution_select_i = 1'h1;
		strobe('0, '0, '0, 4'h8);
		seq(12'h825, 1'b1, 1'b0, 1'b0);
		chk(general_overrun_flag_o, 1'b1);
		chk(channel_overrun_flag_o, 12'h825);
		strobe('0, '0, '0, 4'h1);
		chk(channel_overrun_flag_o, 12'h000);
		strobe('0, '0, '0, 4'h2);
		chk(general_overrun_flag_o, 1'b0);
		strobe('0, '0, 12'h001, 4'h4);
		chk(end_of_conversion_o, 12'h824);
		idle();
		hw(3'h1, 1'h1, 1'b1);
		hw(3'h1, 1'h0, 1'b0);
		hw(3'h2, 1'h1, 1'b0);
		hw(3'h2, 1'h0, 1'b1);
		hw(3'h3, 1'h1, 1'b1);
		hw(3'h3, 1'h0, 1'b1);
		hw(3'h4, 1'h0, 1'b1);
		hw(3'h5, 1'h0, 1'b1);
		trigger_mode_select_i = 3'h0;
		idle();
		spc(8'h00, 4'h0, 2'h0, s0);
		spc(8'h02, 4'h0, 2'h0, s1);
		chk(s1, 3 * s0);
		spc(8'hFF, 4'h0, 2'h0, s1);
		chk(s1, 256 * s0);
		spc(8'h00, 4'h7, 2'h0, s1);
		chk(s1 > s0, 1'b1);
		spc(8'h00, 4'h3, 2'h3, s1);
		chk(s1 < 16, 1'b1);
		clock_enable_i = 1'h0;
		strobe('0, 12'h800, '0, 4'h8);
		chk(channel_status_o, 12'h025);
		step(50);
		chk(busy_o, 1'b0);
		clock_enable_i = 1'h1;
		wait_smp(t);
		idle();
		end_of_test();
	end
endmodule : acc_controller_tb
